//--- include/icr_defines.svh
// Register offsets, field positions, reset values and timing figures of the
// interrupt control block. Assumes it is included by bare name once per file.
`ifndef ICR_DEFINES_SVH
`define ICR_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ICR_OFF_CTRL 12'h000
`define ICR_OFF_STATUS 12'h004
`define ICR_OFF_MASK 12'h008
`define ICR_OFF_DISCNT 12'h00C

// ****************************************************************
// Control register fields
// ****************************************************************
`define ICR_BIT_GIE 15
`define ICR_BIT_TIMED_DISABLE_ACTIVE 14
`define ICR_BIT_SOFT_TRAP_ENABLE 13
`define ICR_BIT_ALTVT 8
`define ICR_POL_HI 2
`define ICR_POL_LO 0
`define ICR_CTRL_RESET 16'h8000
`define ICR_CTRL_WMASK 16'hA107

// ****************************************************************
// Bus answers, widths and clock period
// ****************************************************************
`define ICR_RESP_OKAY 2'h0
`define ICR_RESP_SLVERR 2'h2
`define ICR_NUM_EXT 3
`define ICR_CLK_PERIOD_NS 100

`endif

//--- include/icr_pkg.sv
// Types shared by the interrupt control block.
// Assumes icr_defines.svh is on the include path.
package icr_pkg;
    // One 16-bit software register.
    typedef logic [15:0] icr_word_t;
    // Which register an address selects.
    typedef enum logic [2:0] {SEL_CTRL, SEL_STATUS, SEL_MASK, SEL_DISCNT, SEL_NONE} icr_sel_t;
endpackage

//--- hdl/icr_ctrl.sv
// Interrupt control register with edge-detected external requests, reached
// over AXI4-Lite. Assumes a single 10 MHz clock and a synchronous reset.
//
// Behaviour
// - Global enable gates interrupts; traps always pass.
// - Timed-disable status reads one while active.
// - Soft trap bit writable and reads back.
// - Alternate vector table select drives vector fetch.
// - Polarity one means falling edge, else rising.
// - Unassigned control bits ignore writes, read zero.
`timescale 1ns/100ps
`include "icr_defines.svh"

module icr_ctrl #(
    parameter int NUM_EXT = `ICR_NUM_EXT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_EXT-1:0] ext_irq_in,
    output logic irq_out,
    output logic soft_trap_out,
    output logic alt_vector_table_out
);

    // ****************************************************************
    // State
    // ****************************************************************
    icr_pkg::icr_word_t ctrl_r, ctrl_nxt;          // Stored control bits.
    logic [NUM_EXT-1:0] status_r, status_nxt;      // Sticky edge flags.
    logic [NUM_EXT-1:0] mask_r, mask_nxt;          // Per-source enables.
    logic [15:0] discnt_r, discnt_nxt;             // Timed-disable countdown.
    logic [NUM_EXT-1:0] sync1_r, sync2_r, sync3_r; // Input synchroniser.
    logic aw_held_r, aw_held_nxt;                  // Write address captured.
    logic [11:0] aw_addr_r, aw_addr_nxt;
    logic w_held_r, w_held_nxt;                    // Write data captured.
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic irq_r, irq_nxt;
    logic trap_r, trap_nxt;
    logic altvt_r, altvt_nxt;
    logic [NUM_EXT-1:0] edge_hit;                  // Qualifying edges this cycle.
    logic timed_disable_active_active;

    // Address decode, shared by the read and write paths.
    function automatic icr_pkg::icr_sel_t decode(input logic [11:0] addr);
        icr_pkg::icr_sel_t sel;
        if (addr == `ICR_OFF_CTRL) begin
            sel = icr_pkg::SEL_CTRL;
        end else if (addr == `ICR_OFF_STATUS) begin
            sel = icr_pkg::SEL_STATUS;
        end else if (addr == `ICR_OFF_MASK) begin
            sel = icr_pkg::SEL_MASK;
        end else if (addr == `ICR_OFF_DISCNT) begin
            sel = icr_pkg::SEL_DISCNT;
        end else begin
            sel = icr_pkg::SEL_NONE;
        end
        return sel;
    endfunction

    // Byte-lane merge of a 16-bit register with write data.
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // ****************************************************************
    // Edge detection
    // ****************************************************************
    // Only the second and third stages are compared, so a metastable first
    // stage never reaches the edge logic. Each edge is one cycle wide.
    assign timed_disable_active_active = (discnt_r != 16'h0000);
    always_comb begin
        for (int i = 0; i < NUM_EXT; i++) begin
            if (ctrl_r[`ICR_POL_LO + i]) begin
                edge_hit[i] = sync3_r[i] & ~sync2_r[i];
            end else begin
                edge_hit[i] = sync2_r[i] & ~sync3_r[i];
            end
        end
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // Writes complete only once address and data are both held and the
    // previous response has gone, so one write is in flight at a time.
    always_comb begin
        logic [15:0] wv;
        logic [NUM_EXT-1:0] clr;
        wv = 16'h0000;
        clr = '0;
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        discnt_nxt = timed_disable_active_active ? discnt_r - 16'h0001 : discnt_r;
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt = w_held_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_awvalid && awready_r) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_held_r && w_held_r && !bvalid_r) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = `ICR_RESP_OKAY;
            case (decode(aw_addr_r))
                icr_pkg::SEL_CTRL: begin
                    // Status and unassigned positions are not stored.
                    wv = merge(ctrl_r, w_data_r, w_strb_r);
                    ctrl_nxt = wv & `ICR_CTRL_WMASK;
                end
                icr_pkg::SEL_STATUS: begin
                    wv = merge(16'h0000, w_data_r, w_strb_r);
                    clr = wv[NUM_EXT-1:0];
                end
                icr_pkg::SEL_MASK: begin
                    wv = merge({{(16-NUM_EXT){1'b0}}, mask_r}, w_data_r, w_strb_r);
                    mask_nxt = wv[NUM_EXT-1:0];
                end
                icr_pkg::SEL_DISCNT: begin
                    discnt_nxt = merge(discnt_r, w_data_r, w_strb_r);
                end
                default: begin
                    bresp_nxt = `ICR_RESP_SLVERR;
                end
            endcase
        end
        // A new edge wins over a clear in the same cycle.
        status_nxt = (status_r & ~clr) | edge_hit;
        awready_nxt = !aw_held_nxt;
        wready_nxt = !w_held_nxt;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `ICR_RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            case (decode(s_axi_araddr))
                icr_pkg::SEL_CTRL: begin
                    rdata_nxt[15:0] = ctrl_r;
                    rdata_nxt[`ICR_BIT_TIMED_DISABLE_ACTIVE] = timed_disable_active_active;
                end
                icr_pkg::SEL_STATUS: rdata_nxt[NUM_EXT-1:0] = status_r;
                icr_pkg::SEL_MASK: rdata_nxt[NUM_EXT-1:0] = mask_r;
                icr_pkg::SEL_DISCNT: rdata_nxt[15:0] = discnt_r;
                default: rresp_nxt = `ICR_RESP_SLVERR;
            endcase
        end
        // Address ready tracks the free read slot, so it also rises after reset.
        arready_nxt = !rvalid_nxt;
        // Timed disable holds off maskable requests; traps never wait.
        irq_nxt = ctrl_r[`ICR_BIT_GIE] && !timed_disable_active_active && |(status_r & mask_r);
        trap_nxt = ctrl_r[`ICR_BIT_SOFT_TRAP_ENABLE];
        altvt_nxt = ctrl_r[`ICR_BIT_ALTVT];
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Every register runs each edge; reset forces control to its default.
    always_ff @(posedge aclk) begin
        sync1_r <= ext_irq_in;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
        if (!aresetn) begin
            ctrl_r <= `ICR_CTRL_RESET;
            status_r <= '0;
            mask_r <= '0;
            discnt_r <= 16'h0000;
            aw_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `ICR_RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `ICR_RESP_OKAY;
            irq_r <= 1'b0;
            trap_r <= 1'b0;
            altvt_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            discnt_r <= discnt_nxt;
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r <= w_held_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            irq_r <= irq_nxt;
            trap_r <= trap_nxt;
            altvt_r <= altvt_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign irq_out = irq_r;
    assign soft_trap_out = trap_r;
    assign alt_vector_table_out = altvt_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    gie_gates_irq_a: assert property (!ctrl_r[`ICR_BIT_GIE] |=> !irq_r)
        else $error("interrupt raised with global enable clear");
    timed_disable_active_reads_a: assert property (rvalid_r && $past(s_axi_arvalid && arready_r)
        && $past(decode(s_axi_araddr) == icr_pkg::SEL_CTRL)
        |-> rdata_r[`ICR_BIT_TIMED_DISABLE_ACTIVE] == $past(timed_disable_active_active))
        else $error("timed-disable status read back wrong");
    trap_follows_a: assert property (ctrl_r[`ICR_BIT_SOFT_TRAP_ENABLE] [*2] |-> trap_r)
        else $error("soft trap output does not follow its bit");
    altvt_follows_a: assert property ($changed(ctrl_r[`ICR_BIT_ALTVT])
        |=> altvt_r == $past(ctrl_r[`ICR_BIT_ALTVT]))
        else $error("alternate table select not driven");
    fall_edge_a: assert property (ctrl_r[`ICR_POL_LO] && sync3_r[0] && !sync2_r[0]
        |=> status_r[0])
        else $error("falling edge missed with polarity set");
    rise_only_a: assert property ($rose(status_r[0]) |->
        $past(ctrl_r[`ICR_POL_LO] ? (sync3_r[0] && !sync2_r[0])
                                  : (sync2_r[0] && !sync3_r[0])))
        else $error("flag set without a qualifying edge");
    reserved_zero_a: assert property ((ctrl_r & ~`ICR_CTRL_WMASK) == 16'h0000)
        else $error("unassigned control bits are nonzero");
    one_edge_once_a: assert property (edge_hit[0] |=> !edge_hit[0])
        else $error("one edge counted twice");

endmodule

//--- tb/icr_pin_model.sv
// Model of the outside sources that drive the external request pins.
// Assumes the bench calls set_pin right after a rising clock edge.
`timescale 1ns/100ps

module icr_pin_model #(
    parameter int NUM = 3,
    parameter int HOLD = 6
) (
    input wire logic aclk,
    output logic [NUM-1:0] pins
);
    // The pins idle low, so the first rising edge is a real event.
    initial begin
        pins = '0;
    end

    // A level is held for HOLD cycles, far above one clock, so the
    // synchroniser can never miss it; short glitches are not modelled.
    task automatic set_pin(input int idx, input logic lvl);
        pins[idx] <= lvl;
        repeat (HOLD) @(posedge aclk);
    endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the interrupt control block.
// Assumes the design and the pin model are compiled before this file.
`timescale 1ns/100ps
`include "icr_defines.svh"

module tb_top;
    // ****************************************************************
    // Signals and counters
    // ****************************************************************
    logic aclk = 1'h0; // System clock, 10 MHz.
    logic aresetn = 1'h0; // Synchronous reset, active low.
    logic [11:0] awaddr = 12'h000;
    logic awvalid = 1'h0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF; // Byte lanes of the write data.
    logic wvalid = 1'h0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'h0;
    logic [11:0] araddr = 12'h000;
    logic arvalid = 1'h0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'h0;
    logic [2:0] pins; // Driven by the pin model.
    logic irq;
    logic trap;
    logic alt;
    logic [1:0] resp; // Answer code of the last transfer.
    logic [31:0] rd; // Data of the last read.
    int fail_count = 0;
    int checks_done = 0;

    // The clock toggles every half period of 100 ns.
    always #50 aclk = ~aclk;

    icr_pin_model pin (.aclk(aclk), .pins(pins));

    icr_ctrl DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_irq_in(pins),
        .irq_out(irq), .soft_trap_out(trap), .alt_vector_table_out(alt)
    );

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    // Address and data go out together; each drops once taken. The task
    // ends one edge after the response so bready never toggles twice.
    // Only the watchdog ends a wait for an answer that never comes.
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hF);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rdr(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rd = rdata;
        resp = rresp;
        rready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        rdr(a);
        chk(rd, exp);
    endtask

    // The interrupt line is registered, so let it settle first.
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        rd_chk(`ICR_OFF_CTRL, 32'h0000_8000);
        rd_chk(`ICR_OFF_STATUS, 32'h0);
        rd_chk(`ICR_OFF_MASK, 32'h0);
        chk({29'h0, irq, trap, alt}, 32'h0);
    endtask

    // All ones written: only the assigned bits may stick.
    task automatic t_ctrl();
        wr(`ICR_OFF_CTRL, 32'hFFFF_FFFF);
        rd_chk(`ICR_OFF_CTRL, 32'h0000_A107);
        chk({30'h0, trap, alt}, 32'h3);
        // The trap still passes with the global enable clear.
        wr(`ICR_OFF_CTRL, 32'h0000_2000);
        chk({31'h0, trap}, 32'h1);
        wr(`ICR_OFF_CTRL, 32'h0000_8000);
        rd_chk(`ICR_OFF_CTRL, 32'h0000_8000);
        chk({30'h0, trap, alt}, 32'h0);
        // Low lane only: the upper byte, global enable included, must stay.
        wr(`ICR_OFF_CTRL, 32'h0000_00FF, 4'h1);
        rd_chk(`ICR_OFF_CTRL, 32'h0000_8007);
        wr(`ICR_OFF_CTRL, 32'h0000_8000);
    endtask

    // Global enable, timed disable and mask each gate one request; a clear then drops its flag.
    task automatic t_gate();
        wr(`ICR_OFF_CTRL, 32'h0);
        wr(`ICR_OFF_MASK, 32'h1);
        pin.set_pin(0, 1'h1);
        rd_chk(`ICR_OFF_STATUS, 32'h1);
        irq_chk(1'h0);
        wr(`ICR_OFF_CTRL, 32'h0000_8000);
        irq_chk(1'h1);
        wr(`ICR_OFF_DISCNT, 32'd20);
        irq_chk(1'h0);
        rd_chk(`ICR_OFF_CTRL, 32'h0000_C000);
        repeat (25) @(posedge aclk);
        rd_chk(`ICR_OFF_CTRL, 32'h0000_8000);
        irq_chk(1'h1);
        wr(`ICR_OFF_MASK, 32'h0);
        irq_chk(1'h0);
        wr(`ICR_OFF_STATUS, 32'h1);
        rd_chk(`ICR_OFF_STATUS, 32'h0);
        pin.set_pin(0, 1'h0);
    endtask

    // Each pin under both polarities; the wrong edge must not count.
    task automatic t_edges();
        for (int i = 0; i < 3; i++) begin
            wr(`ICR_OFF_CTRL, 32'h0000_8000);
            pin.set_pin(i, 1'h1);
            rd_chk(`ICR_OFF_STATUS, 32'h1 << i);
            wr(`ICR_OFF_STATUS, 32'h1 << i);
            pin.set_pin(i, 1'h0);
            rd_chk(`ICR_OFF_STATUS, 32'h0);
            wr(`ICR_OFF_CTRL, 32'h0000_8000 | (32'h1 << i));
            pin.set_pin(i, 1'h1);
            rd_chk(`ICR_OFF_STATUS, 32'h0);
            pin.set_pin(i, 1'h0);
            rd_chk(`ICR_OFF_STATUS, 32'h1 << i);
            wr(`ICR_OFF_STATUS, 32'h1 << i);
            rd_chk(`ICR_OFF_STATUS, 32'h0);
        end
    endtask

    // An unmapped place answers with an error and changes nothing.
    task automatic t_unmapped();
        wr(12'h010, 32'hFFFF_FFFF);
        chk({30'h0, resp}, {30'h0, `ICR_RESP_SLVERR});
        rdr(12'h010);
        chk({rd[29:0], resp}, {30'h0, `ICR_RESP_SLVERR});
        // The edge scenario left falling polarity on the last pin.
        rd_chk(`ICR_OFF_CTRL, 32'h0000_8004);
    endtask

    // ****************************************************************
    // Sequence, watchdog and verdict
    // ****************************************************************
    task automatic summarize();
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset();
        t_ctrl();
        t_gate();
        t_edges();
        t_unmapped();
        summarize();
    end

    // The run needs well under 2000 cycles; this cuts a hang short.
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        summarize();
    end
endmodule
